// file: rtl/tpo_top.sv
// Time-proportioning output driver for one shared digital I/O point.
// Assumes tick_100ms and line_pulse are one-cycle pulses synchronous to mclk.
// Function
// - Zero or off demand holds output off when low scale is 0.0
// - Full or on demand holds output on when high scale is 100.0 and the point is an output
// - Accepts on/off or percentage demand
// - Intermediate demands switch by selected time base
// - Average on fraction equals scaled demand
// - Setting selects fixed or line-cycle method
// - Fixed mode: duty cycle within each period
// - Fixed period 0.1 to 60.0 s
// - Line-cycle runs last at least three cycles
// - Six on three off at 66 percent
// - Low scale applies at zero demand
// - High scale applies at full demand
// - Linear map between low and high scale
// - Scales 0.0 to 100.0 percent, tenths
// - Direction setting: only output drives point
// - Output point follows connected demand
`include "tpo_regs.svh"

module tpo_top #(
	parameter int PCT_W = 10
) (
	input  wire logic                 mclk,
	input  wire logic                 reset,
	input  wire tpo_pkg::tpo_bus_s    bus,
	output logic [31:0]               rd_data,
	input  wire tpo_pkg::tpo_demand_s demand,
	input  wire logic                 tick_100ms,
	input  wire logic                 line_pulse,
	input  wire logic                 point_in,
	output logic                      point_out,
	output logic                      point_oe
);
	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic logic [PCT_W-1:0] scale_pct(input logic [PCT_W-1:0] d,
	                                               input logic [PCT_W-1:0] lo,
	                                               input logic [PCT_W-1:0] hi);
		logic [19:0] prod;
		prod = 20'h00000;
		if (hi >= lo) begin
			prod = 20'(hi - lo) * 20'(d);
			scale_pct = lo + PCT_W'(prod / 20'(`TPO_PCT_FULL));
		end else begin
			prod = 20'(lo - hi) * 20'(d);
			scale_pct = lo - PCT_W'(prod / 20'(`TPO_PCT_FULL));
		end
	endfunction

	function automatic logic [PCT_W-1:0] clamp_pct(input logic [31:0] v);
		clamp_pct = (v > 32'(`TPO_PCT_FULL)) ? `TPO_PCT_FULL : PCT_W'(v);
	endfunction

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic             dir_reg;
	logic             var_sel_reg;
	logic [9:0]       period_cfg_reg;
	logic [PCT_W-1:0] low_reg;
	logic [PCT_W-1:0] high_reg;
	logic [PCT_W-1:0] eff_reg;
	logic             var_active_reg;
	logic [31:0]      rd_next;

	always_ff @(posedge mclk) begin
		if (reset) begin
			dir_reg        <= 1'b0;
			var_sel_reg    <= 1'b0;
			period_cfg_reg <= `TPO_PERIOD_RST;
			low_reg        <= `TPO_LOW_RST;
			high_reg       <= `TPO_HIGH_RST;
		end else if (bus.wr) begin
			unique case (bus.addr)
				`TPO_ADDR_CTRL: begin
					dir_reg     <= bus.wdata[`TPO_CTRL_DIR_BIT];
					var_sel_reg <= bus.wdata[`TPO_CTRL_VAR_BIT];
				end
				`TPO_ADDR_PERIOD: begin
					// Out-of-range periods are clamped rather than refused
					if (bus.wdata < 32'(`TPO_PERIOD_MIN))
						period_cfg_reg <= `TPO_PERIOD_MIN;
					else if (bus.wdata > 32'(`TPO_PERIOD_MAX))
						period_cfg_reg <= `TPO_PERIOD_MAX;
					else
						period_cfg_reg <= bus.wdata[9:0];
				end
				`TPO_ADDR_LOW:  low_reg  <= clamp_pct(bus.wdata);
				`TPO_ADDR_HIGH: high_reg <= clamp_pct(bus.wdata);
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_next = 32'h00000000;
		if (bus.rd) begin
			unique case (bus.addr)
				`TPO_ADDR_CTRL: begin
					rd_next[`TPO_CTRL_DIR_BIT] = dir_reg;
					rd_next[`TPO_CTRL_VAR_BIT] = var_sel_reg;
				end
				`TPO_ADDR_PERIOD: rd_next[9:0] = period_cfg_reg;
				`TPO_ADDR_LOW:    rd_next[PCT_W-1:0] = low_reg;
				`TPO_ADDR_HIGH:   rd_next[PCT_W-1:0] = high_reg;
				`TPO_ADDR_STATUS: begin
					rd_next[PCT_W-1:0]      = eff_reg;
					rd_next[`TPO_ST_OUT_BIT] = point_out;
					rd_next[`TPO_ST_VAR_BIT] = var_active_reg;
					rd_next[`TPO_ST_IN_BIT]  = point_in;
				end
				default: rd_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset)
			rd_data <= 32'h00000000;
		else
			rd_data <= rd_next;
	end

	// ------------------------------------------------------------
	// Demand scaling
	// ------------------------------------------------------------
	logic [PCT_W-1:0] raw_pct;

	always_comb begin
		if (demand.is_pct)
			raw_pct = (demand.pct > `TPO_PCT_FULL) ? `TPO_PCT_FULL : demand.pct;
		else
			raw_pct = demand.on ? `TPO_PCT_FULL : PCT_W'(0);
	end

	always_ff @(posedge mclk) begin
		if (reset)
			eff_reg <= PCT_W'(0);
		else
			eff_reg <= scale_pct(raw_pct, low_reg, high_reg);
	end

	logic mid_pwr;
	assign mid_pwr = (eff_reg != PCT_W'(0)) && (eff_reg < `TPO_PCT_FULL);

	// ------------------------------------------------------------
	// Fixed time base
	// ------------------------------------------------------------
	logic [9:0]  per_cnt_reg;
	logic [9:0]  per_len_reg;
	logic [9:0]  on_len_reg;
	logic        per_wrap;
	logic [19:0] on_prod;

	assign per_wrap = tick_100ms && (per_cnt_reg >= per_len_reg - 10'h001);
	assign on_prod  = 20'(eff_reg) * 20'(period_cfg_reg);

	always_ff @(posedge mclk) begin
		if (reset) begin
			per_cnt_reg <= 10'h000;
			per_len_reg <= `TPO_PERIOD_RST;
			on_len_reg  <= 10'h000;
		end else if (per_wrap) begin
			// New length and duty take hold only at a period boundary
			per_cnt_reg <= 10'h000;
			per_len_reg <= period_cfg_reg;
			on_len_reg  <= 10'(on_prod / 20'(`TPO_PCT_FULL));
		end else if (tick_100ms) begin
			per_cnt_reg <= per_cnt_reg + 10'h001;
		end
	end

	logic fix_out;
	assign fix_out = per_cnt_reg < on_len_reg;

	// ------------------------------------------------------------
	// Variable (line-cycle) time base
	// ------------------------------------------------------------
	logic signed [15:0] acc_reg;
	logic signed [15:0] acc_next;
	logic [1:0]         run_reg;
	logic               var_out_reg;
	logic               run_done;

	// Error integrator: hardware toggles only once a run has met its minimum
	assign acc_next = acc_reg + 16'(eff_reg)
	                  - (var_out_reg ? 16'(`TPO_PCT_FULL) : 16'sh0000);
	assign run_done = (run_reg + 2'h1) >= `TPO_RUN_MIN;

	always_ff @(posedge mclk) begin
		if (reset) begin
			acc_reg     <= 16'sh0000;
			run_reg     <= 2'h0;
			var_out_reg <= 1'b0;
		end else if (line_pulse && var_active_reg && mid_pwr) begin
			acc_reg <= acc_next;
			if (run_done && (var_out_reg ? (acc_next <= 16'sh0000)
			                             : (acc_next > 16'sh0000))) begin
				var_out_reg <= !var_out_reg;
				run_reg     <= 2'h0;
			end else if (!run_done) begin
				run_reg <= run_reg + 2'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Time base selection
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset)
			var_active_reg <= 1'b0;
		else if (!mid_pwr)
			var_active_reg <= var_sel_reg;
		else if (!var_active_reg && per_wrap)
			var_active_reg <= var_sel_reg;
		else if (var_active_reg && line_pulse && run_done)
			var_active_reg <= var_sel_reg;
	end

	// ------------------------------------------------------------
	// Point drive
	// ------------------------------------------------------------
	logic out_next;

	always_comb begin
		if (!dir_reg)
			out_next = 1'b0;
		else if (eff_reg == PCT_W'(0))
			out_next = 1'b0;
		else if (eff_reg >= `TPO_PCT_FULL)
			out_next = 1'b1;
		else
			out_next = var_active_reg ? var_out_reg : fix_out;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			point_out <= 1'b0;
			point_oe  <= 1'b0;
		end else begin
			point_out <= out_next;
			point_oe  <= dir_reg;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence s_period_end;
		tick_100ms && (per_cnt_reg >= per_len_reg - 10'h001);
	endsequence

	sequence s_zero_demand;
		demand.is_pct && (demand.pct == 10'h000);
	endsequence

	a_off_at_zero: assert property ((eff_reg == 10'h000) |=> !point_out)
		else $error("output on at zero power");
	a_on_at_full: assert property (dir_reg && eff_reg == 10'h3E8 |=> point_out)
		else $error("output off at full power");
	a_low_scale_map: assert property (s_zero_demand |=> eff_reg == $past(low_reg))
		else $error("zero demand not mapped to low scale");
	a_high_scale_map: assert property (!demand.is_pct && demand.on
		|=> eff_reg == $past(high_reg))
		else $error("on demand not mapped to high scale");
	a_period_latch: assert property (s_period_end
		|=> per_cnt_reg == 10'h000 && per_len_reg == $past(period_cfg_reg))
		else $error("period settings not taken at boundary");
	a_period_range: assert property (per_len_reg >= 10'h001 && per_len_reg <= 10'h258)
		else $error("period length out of range");
	a_fixed_duty: assert property (dir_reg && mid_pwr && !var_active_reg
		|=> point_out == $past(fix_out))
		else $error("fixed duty mismatch");
	a_min_run: assert property ($changed(var_out_reg) |-> $past(run_reg) >= 2'h2)
		else $error("line-cycle run shorter than three");
	a_input_hiz: assert property (!dir_reg |=> !point_oe && !point_out)
		else $error("point driven while configured as input");
	a_tick_count: assert property (tick_100ms && !per_wrap
		|=> per_cnt_reg == $past(per_cnt_reg) + 10'h001)
		else $error("period tick not counted");
endmodule

// file: rtl/tpo_regs.svh
// Register offsets, field positions, reset values and counts of the output driver.
// Assumes a plain strobe bus with byte addresses on word boundaries.
`ifndef TPO_REGS_SVH
`define TPO_REGS_SVH
`define TPO_ADDR_CTRL     8'h00
`define TPO_ADDR_PERIOD   8'h04
`define TPO_ADDR_LOW      8'h08
`define TPO_ADDR_HIGH     8'h0C
`define TPO_ADDR_STATUS   8'h10
`define TPO_CTRL_DIR_BIT  0
`define TPO_CTRL_VAR_BIT  1
`define TPO_ST_OUT_BIT    16
`define TPO_ST_VAR_BIT    17
`define TPO_ST_IN_BIT     18
`define TPO_PERIOD_RST    10'h064
`define TPO_PERIOD_MIN    10'h001
`define TPO_PERIOD_MAX    10'h258
`define TPO_PCT_FULL      10'h3E8
`define TPO_LOW_RST       10'h000
`define TPO_HIGH_RST      10'h3E8
`define TPO_RUN_MIN       2'h3
`endif

// file: rtl/tpo_pkg.sv
// Types shared by the output driver and its surroundings.
// Assumes tpo_regs.svh holds the numeric constants.
package tpo_pkg;
	typedef struct packed {
		logic       is_pct;
		logic       on;
		logic [9:0] pct;
	} tpo_demand_s;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} tpo_bus_s;

	typedef logic [9:0] tpo_pct_t;
endpackage

// file: tb/tpo_load.sv
// Far-side model: a switched load on the shared point, plus a field contact.
// Assumes line_pulse is the same one-cycle pulse that the driver sees.
module tpo_load (
	input  wire logic mclk,
	input  wire logic line_pulse,
	input  wire logic point_out,
	input  wire logic point_oe,
	input  wire logic field_level,
	input  wire logic check_runs,
	output logic      point_in,
	output int        short_runs
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] run_cnt = 2'h0;
	logic       last    = 1'b0;

	// Driven point shows the drive level, otherwise the field contact
	assign point_in = point_oe ? point_out : field_level;

	// Counts line cycles per run; a run shorter than three cycles wears the switch
	always @(posedge mclk) begin
		if (point_out !== last && check_runs && run_cnt < 2'h3)
			short_runs <= short_runs + 1;
		if (point_out !== last)
			run_cnt <= 2'h0;
		else if (line_pulse && run_cnt < 2'h3)
			run_cnt <= run_cnt + 2'h1;
		last <= point_out;
	end
endmodule

// file: tb/test_tpo_top.sv
// Self-checking bench for the time-proportioning output driver.
// Assumes fast tick and line pulses so that whole periods fit in a short run.
`include "tpo_regs.svh"

module test_tpo_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic                 mclk, reset, tick_100ms, line_pulse, point_in;
	logic                 point_out, point_oe, field_level, check_runs;
	tpo_pkg::tpo_bus_s    bus;
	tpo_pkg::tpo_demand_s demand;
	logic [31:0]          rd_data, d;
	int                   n_fail, compares, short_runs, cyc, n;
	logic [9:0]           pin [4] = '{10'h000, 10'h0FA, 10'h1F4, 10'h3E8};
	logic [9:0]           pex [4] = '{10'h0C8, 10'h15E, 10'h1F4, 10'h320};

	tpo_top tpo_top_inst (.mclk(mclk), .reset(reset), .bus(bus), .rd_data(rd_data),
		.demand(demand), .tick_100ms(tick_100ms), .line_pulse(line_pulse),
		.point_in(point_in), .point_out(point_out), .point_oe(point_oe));
	tpo_load tpo_load_inst (.mclk(mclk), .line_pulse(line_pulse), .point_out(point_out),
		.point_oe(point_oe), .field_level(field_level), .check_runs(check_runs),
		.point_in(point_in), .short_runs(short_runs));

	// --------------------------------
	// Clock and time bases
	// --------------------------------
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		tick_100ms <= (cyc % 8 == 7);
		line_pulse <= (cyc % 5 == 4);
	end

	// --------------------------------
	// Shared tasks
	// --------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		bus <= '{1'b1, 1'b0, a, v};
		@(posedge mclk);
		bus.wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge mclk);
		bus <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1 d = rd_data;
	endtask

	// Counts on samples at k ticks, or at k line pulses when sel is high
	task cnt_on(input int k, input logic sel);
		n = 0;
		repeat (k) begin
			do @(posedge mclk); while ((sel ? line_pulse : tick_100ms) !== 1'b1);
			n += (point_out === 1'b1);
		end
	endtask

	task set_demand(input logic p, input logic o, input logic [9:0] v);
		@(posedge mclk);
		demand <= '{p, o, v};
	endtask

	// --------------------------------
	// Scenarios
	// --------------------------------
	task t_reset;
		chk(point_oe, 32'h0);
		chk(point_out, 32'h0);
		rd(`TPO_ADDR_CTRL);
		chk(d, 32'h0);
		rd(`TPO_ADDR_PERIOD);
		chk(d, 32'h64);
		rd(`TPO_ADDR_LOW);
		chk(d, 32'h0);
		rd(`TPO_ADDR_HIGH);
		chk(d, 32'h3E8);
		rd(8'h14);
		chk(d, 32'h0);
	endtask

	task t_direction;
		set_demand(1'b0, 1'b1, 10'h0);
		field_level <= 1'b1;
		wr(`TPO_ADDR_CTRL, 32'h0);
		repeat (4) @(posedge mclk);
		chk(point_oe, 32'h0);
		chk(point_out, 32'h0);
		rd(`TPO_ADDR_STATUS);
		chk(d[18], 32'h1);
		@(posedge mclk);
		field_level <= 1'b0;
		rd(`TPO_ADDR_STATUS);
		chk(d[18], 32'h0);
	endtask

	task t_levels;
		wr(`TPO_ADDR_CTRL, 32'h1);
		repeat (3) @(posedge mclk);
		#1 chk(point_oe, 32'h1);
		chk(point_out, 32'h1);
		cnt_on(12, 1'b0);
		chk(n, 12);
		demand <= '{1'b1, 1'b0, 10'h3E8};
		cnt_on(12, 1'b0);
		chk(n, 12);
		demand <= '{1'b1, 1'b0, 10'h0};
		cnt_on(12, 1'b0);
		chk(n, 0);
		demand <= '{1'b0, 1'b0, 10'h3E8};
		cnt_on(12, 1'b0);
		chk(n, 0);
	endtask

	task t_scale;
		wr(`TPO_ADDR_LOW, 32'hC8);
		wr(`TPO_ADDR_HIGH, 32'h320);
		for (int i = 0; i < 4; i++) begin
			set_demand(1'b1, 1'b0, pin[i]);
			repeat (3) @(posedge mclk);
			rd(`TPO_ADDR_STATUS);
			chk(d[9:0], pex[i]);
		end
		wr(`TPO_ADDR_LOW, 32'h7D0);
		rd(`TPO_ADDR_LOW);
		chk(d, 32'h3E8);
		wr(`TPO_ADDR_PERIOD, 32'h0);
		rd(`TPO_ADDR_PERIOD);
		chk(d, 32'h1);
		wr(`TPO_ADDR_PERIOD, 32'h2BC);
		rd(`TPO_ADDR_PERIOD);
		chk(d, 32'h258);
		wr(`TPO_ADDR_LOW, 32'h0);
		wr(`TPO_ADDR_HIGH, 32'h3E8);
	endtask

	task t_fixed;
		// The shorter period only lands once the 100-tick reset period wraps
		wr(`TPO_ADDR_PERIOD, 32'hA);
		set_demand(1'b1, 1'b0, 10'h2EE);
		cnt_on(110, 1'b0);
		cnt_on(20, 1'b0);
		chk(n, 14);
		rd(`TPO_ADDR_STATUS);
		chk(d[17], 32'h0);
	endtask

	task t_variable;
		wr(`TPO_ADDR_CTRL, 32'h3);
		set_demand(1'b1, 1'b0, 10'h1F4);
		cnt_on(40, 1'b1);
		rd(`TPO_ADDR_STATUS);
		chk(d[17], 32'h1);
		check_runs <= 1'b1;
		cnt_on(36, 1'b1);
		chk(n, 18);
		demand <= '{1'b1, 1'b0, 10'h29B};
		cnt_on(18, 1'b1);
		cnt_on(36, 1'b1);
		chk(n >= 21 && n <= 27, 32'h1);
		chk(short_runs, 0);
	endtask

	task conclude;
		if (n_fail == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		reset = 1'b1;
		bus = '0;
		demand = '0;
		field_level = 1'b0;
		check_runs = 1'b0;
		n_fail = 0;
		compares = 0;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		#1;
		t_reset;
		t_direction;
		t_levels;
		t_scale;
		t_fixed;
		t_variable;
		conclude;
	end

	// About five times the expected run length
	initial begin
		#(25 * 10000);
		n_fail++;
		conclude;
	end
endmodule
